/* File: sim/pscd_dac_model.sv */
`timescale 1ns/10ps
`default_nettype none
// DAC register side: accepts writes while stalling every other cycle.
module pscd_dac_model (
  input  wire logic        i_clk,
  input  wire logic        i_valid,
  input  wire logic [19:0] i_addr,
  input  wire logic [11:0] i_data,
  output logic             o_ready,
  output logic [63:0]      o_log
);
  initial o_ready = 1'b0;
  // Ready toggles so a write waits at most one cycle; the last two accepted writes are kept in order.
  always @(posedge i_clk) begin
    if (i_valid && o_ready) o_log <= {o_log[31:0], i_addr, i_data};
    o_ready <= ~o_ready;
  end
endmodule
`default_nettype wire

/* File: sim/pscd_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pscd_top_tb;
  import pscd_pkg::*;
  logic         clk = 1'b0, nrst = 1'b0, cv = 1'b0, aw = 1'b0, crdy, wv, rdy, tt, pt, st;
  logic [15:0]  topd = 16'h0005, om = 16'h3777;
  logic [3:0]   phd = 4'h2, svd = 4'h1;
  logic [31:0]  hw = 32'h1717_1717, dec = 32'h3337_3333, inv = 32'h0000_0000;
  logic [1:0]   sw = 2'h0;
  logic [23:0]  sv = 24'h00_0000;
  logic [7:0]   act = 8'h05, cen = 8'h0a, ea = 8'h00, eb = 8'h00, rs = 8'h00, rd = 8'h00;
  logic [7:0]   cm, su, ab, cpwm, pfm, fy;
  logic [2:0]   am = 3'h2, cmo = 3'h1;
  logic [19:0]  coa = 20'h0c012, fba = 20'h8c0a3, wa;
  logic [11:0]  ca = 12'h123, cb = 12'h456, wd;
  logic [127:0] cyc = {8{16'h0004}};
  logic [191:0] cnt = {8{24'h00_1000}};
  logic [63:0]  ang = {8{8'h55}}, wlog;
  logic [63:0]  anga, angb;
  logic [191:0] epos;
  logic [1:0][3:0] hwt;
  logic [1:0]   dstb;
  logic [7:0]   sdat;
  logic         pws;
  int           n_fail = 0, num_checks = 0;

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  pscd_top dut (
    .i_clk(clk), .i_nrst(nrst), .i_top_phase_divider(topd), .i_phase_clock_divider(phd),
    .i_servo_clock_divider(svd), .i_hw_clock_select_low_group(hw), .i_hw_clock_select_high_group(hw),
    .i_strobe_wr(sw), .i_strobe_value(sv), .i_encoder_decode_setting(dec), .i_output_mode_setting(om),
    .i_dac_stream_inversion(inv), .i_motor_activation(act), .i_commutation_enable(cen), .i_addr_wr(aw),
    .i_addr_motor(am), .i_command_output_address(coa), .i_commutation_feedback_address(fba),
    .i_cycles_per_revolution(cyc), .i_counts_per_revolution(cnt), .i_phase_a_to_b_angle(ang),
    .i_enc_a(ea), .i_enc_b(eb), .i_ring_step(rs), .i_ring_dir(rd), .i_cmd_valid(cv), .o_cmd_ready(crdy),
    .i_cmd_motor(cmo), .i_cmd_a(ca), .i_cmd_b(cb), .o_dac_wr_valid(wv), .i_dac_wr_ready(rdy),
    .o_dac_wr_addr(wa), .o_dac_wr_data(wd), .o_top_phase_tick(tt), .o_pwm_cycle_start(pws), .o_phase_tick(pt),
    .o_servo_tick(st), .o_commutate(cm), .o_servo_update(su), .o_hw_clk_tick(hwt), .o_dac_strobe(dstb),
    .o_dac_sdata(sdat), .o_enc_phase_pos(epos), .o_ab_dac_mode(ab), .o_c_pwm_mode(cpwm), .o_c_pfm_mode(pfm),
    .o_fb_from_y(fy), .o_angle_a(anga), .o_angle_b(angb)
  );

  pscd_dac_model u_dac (.i_clk(clk), .i_valid(wv), .i_addr(wa), .i_data(wd), .o_ready(rdy), .o_log(wlog));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Counts top and phase ticks over one whole servo period and checks the gated pulses.
  task automatic t_div();
    int nt, np;
    nt = 0;
    np = 0;
    do @(negedge clk); while (st !== 1'b1);
    chk("commutate", {56'h0, cen}, {56'h0, cm});
    chk("servo_update", {56'h0, act}, {56'h0, su});
    do begin
      @(negedge clk);
      nt += int'(tt);
      np += int'(pt);
    end while (st !== 1'b1);
    chk("phase_per_servo", 64'(svd) + 1, 64'(np));
    chk("top_per_servo", (64'(phd) + 1) * (64'(svd) + 1), 64'(nt));
  endtask

  // One command word becomes two DAC writes at the default address and the next one.
  task automatic t_cmd();
    cv = 1'b1;
    @(negedge clk);
    cv = 1'b0;
    do @(negedge clk); while (wv !== 1'b1);
    do @(negedge clk); while (wv !== 1'b0);
    chk("dac_writes", {20'h0c00a, ca, 20'h0c00b, cb}, wlog);
  endtask

  // Loads a ring node feedback address and checks the mode decode.
  task automatic t_cfg();
    aw = 1'b1;
    @(negedge clk);
    aw = 1'b0;
    repeat (2) @(negedge clk);
    chk("fb_from_y", 64'h04, {56'h0, fy});
    chk("modes", {40'h0, 8'h7f, 8'h2a, 8'h55}, {40'h0, ab, cpwm, pfm});
  endtask

  // Filters a short pin glitch, then walks four B-leading quadrature steps on channels 0 and 4.
  task automatic t_enc();
    logic [3:0] qa, qb;
    qa = 4'b0110;
    qb = 4'b0011;
    ea = 8'h02;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      ea = {3'h0, qa[i], 3'h0, qa[i]};
      eb = {3'h0, qb[i], 3'h0, qb[i]};
      repeat (40) @(negedge clk);
    end
    chk("enc_glitch", 64'h0, {40'h0, epos[47:24]});
    chk("enc_fwd", 64'h4, {40'h0, epos[23:0]});
    chk("enc_rev", 64'hff_fffc, {40'h0, epos[119:96]});
    chk("angle_fwd", 64'h0156, {48'h0, anga[7:0], angb[7:0]});
    chk("angle_rev", 64'hff, {56'h0, anga[39:32]});
  endtask

  // At setting 255 the top phase clock is 230.4 kHz, so one period is 108 or 109 cycles.
  task automatic t_top();
    int n;
    n = 0;
    // Software would recompute the interpolation time after this divider change.
    topd = 16'h00ff;
    do @(negedge clk); while (tt !== 1'b1);
    chk("pwm_start", 64'h1, {63'h0, pws});
    do begin
      @(negedge clk);
      n++;
    end while (tt !== 1'b1);
    chk("top_period", 64'h1, {63'h0, (n == 108) || (n == 109)});
  endtask

  // Captures the group 0 strobe frame and the channel 1 data stream, one bit per DAC tick.
  task automatic t_ser(input logic [23:0] exp_stb, input logic [23:0] exp_dat);
    logic [23:0] sb, sd;
    logic        prv;
    int          k;
    sb = '0;
    sd = '0;
    prv = 1'b0;
    k = 0;
    do @(negedge clk); while (pt !== 1'b1);
    while (k < 24) begin
      @(negedge clk);
      if (prv) begin
        sb = {sb[22:0], dstb[0]};
        sd = {sd[22:0], sdat[1]};
        k++;
      end
      prv = hwt[0][2];
    end
    chk("strobe_word", {40'h0, exp_stb}, {40'h0, sb});
    chk("dac_stream", {40'h0, exp_dat}, {40'h0, sd});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence after a 12-cycle reset.
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_div();
    t_cmd();
    t_cfg();
    t_enc();
    t_top();
    t_ser(24'h7f_ffc0, 24'h12_3456);
    inv = 32'h0000_0010;
    sv = 24'h5a_c3a5;
    sw = 2'h1;
    @(negedge clk);
    sw = 2'h0;
    t_ser(24'h5a_c3a5, 24'hed_cba9);
    print_verdict();
  end

  // Watchdog: the whole sequence needs under two thousand cycles of the five thousand allowed.
  initial begin
    #200us;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/pscd_pkg.sv */
`default_nettype none
package pscd_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int N_CH       = 8;
  localparam int NCO_W      = 36;
  localparam int STROBE_W   = 24;
  localparam int CMD_W      = 12;
  localparam int ADR_W      = 20;
  localparam int TOPDIV_W   = 16;
  localparam int DIV_W      = 4;
  localparam int HWSEL_W    = 32;
  localparam int CYC_W      = 16;
  localparam int CNT_W      = 24;
  localparam int POS_W      = 24;
  localparam int ANG_W      = 8;
  localparam int FRAC_W     = 27;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = 3 + 2 * CMD_W;
  // ----------------------------------------
  // Rates: master frequency in units of 0.1 kHz, system clock from its period
  // ----------------------------------------
  localparam logic [NCO_W-1:0] MASTER_FREQ_DHZ = 36'h0_0012_0000;
  localparam int               CLK_PERIOD_NS   = 40;
  localparam logic [NCO_W-1:0] SYS_FREQ_DHZ    = NCO_W'(32'h0098_9680 / CLK_PERIOD_NS);
  // ----------------------------------------
  // Addresses, defaults and encodings
  // ----------------------------------------
  localparam logic [STROBE_W-1:0] STROBE_DEFAULT = 24'h7f_ffc0;
  localparam logic [15:0]         DAC_A_BASE     = 16'hc002;
  localparam logic [15:0]         ENC_POS_BASE   = 16'hc001;
  localparam logic [15:0]         CHAN_STRIDE    = 16'h0008;
  localparam int                  Y_REG_BIT      = 19;
  localparam logic [3:0]          DEC_X4_FWD     = 4'h3;
  localparam logic [3:0]          DEC_X4_REV     = 4'h7;
  localparam logic [1:0]          MODE_DAC_PWM   = 2'h1;
  localparam logic [1:0]          MODE_DAC_PFM   = 2'h3;
  // Hardware clock fields inside a group select word.
  localparam int HW_SCLK = 0;
  localparam int HW_PFM  = 1;
  localparam int HW_DAC  = 2;
  localparam int HW_ADC  = 3;
  typedef enum logic [1:0] {
    DR_IDLE = 2'b00,
    DR_A    = 2'b01,
    DR_B    = 2'b10
  } pscd_drain_t;
endpackage
`default_nettype wire

/* File: verilog/pscd_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Command FIFO
// ----------------------------------------
module pscd_fifo #(
  parameter int W = 27,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
  } pscd_fifo_st_t;
  pscd_fifo_st_t s_r, s_nxt;
  logic push, pop;
  // Pointers move on accepted handshakes; ready is kept registered.
  always_comb begin
    s_nxt = s_r;
    push = i_in_valid & s_r.rdy;
    pop = (s_r.cnt != '0) & i_out_ready;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    s_nxt.rdy = (s_nxt.cnt != (AW+1)'(D));
    if (!i_nrst) begin
      s_nxt = '0;
      s_nxt.rdy = 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end
  assign o_in_ready = s_r.rdy;
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data = s_r.mem[s_r.rp];
endmodule

// ----------------------------------------
// Phase, servo and DAC timing top
// ----------------------------------------
module pscd_top
  import pscd_pkg::*;
(
  input  wire logic                               i_clk,
  input  wire logic                               i_nrst,
  input  wire logic [pscd_pkg::TOPDIV_W-1:0]       i_top_phase_divider,
  input  wire logic [pscd_pkg::DIV_W-1:0]          i_phase_clock_divider,
  input  wire logic [pscd_pkg::DIV_W-1:0]          i_servo_clock_divider,
  input  wire logic [pscd_pkg::HWSEL_W-1:0]        i_hw_clock_select_low_group,
  input  wire logic [pscd_pkg::HWSEL_W-1:0]        i_hw_clock_select_high_group,
  input  wire logic [1:0]                         i_strobe_wr,
  input  wire logic [pscd_pkg::STROBE_W-1:0]       i_strobe_value,
  input  wire logic [pscd_pkg::N_CH*4-1:0]         i_encoder_decode_setting,
  input  wire logic [pscd_pkg::N_CH*2-1:0]         i_output_mode_setting,
  input  wire logic [pscd_pkg::N_CH*4-1:0]         i_dac_stream_inversion,
  input  wire logic [pscd_pkg::N_CH-1:0]           i_motor_activation,
  input  wire logic [pscd_pkg::N_CH-1:0]           i_commutation_enable,
  input  wire logic                               i_addr_wr,
  input  wire logic [2:0]                         i_addr_motor,
  input  wire logic [pscd_pkg::ADR_W-1:0]          i_command_output_address,
  input  wire logic [pscd_pkg::ADR_W-1:0]          i_commutation_feedback_address,
  input  wire logic [pscd_pkg::N_CH*pscd_pkg::CYC_W-1:0] i_cycles_per_revolution,
  input  wire logic [pscd_pkg::N_CH*pscd_pkg::CNT_W-1:0] i_counts_per_revolution,
  input  wire logic [pscd_pkg::N_CH*pscd_pkg::ANG_W-1:0] i_phase_a_to_b_angle,
  input  wire logic [pscd_pkg::N_CH-1:0]           i_enc_a,
  input  wire logic [pscd_pkg::N_CH-1:0]           i_enc_b,
  input  wire logic [pscd_pkg::N_CH-1:0]           i_ring_step,
  input  wire logic [pscd_pkg::N_CH-1:0]           i_ring_dir,
  input  wire logic                               i_cmd_valid,
  output logic                                    o_cmd_ready,
  input  wire logic [2:0]                         i_cmd_motor,
  input  wire logic [pscd_pkg::CMD_W-1:0]          i_cmd_a,
  input  wire logic [pscd_pkg::CMD_W-1:0]          i_cmd_b,
  output logic                                    o_dac_wr_valid,
  input  wire logic                               i_dac_wr_ready,
  output logic [pscd_pkg::ADR_W-1:0]               o_dac_wr_addr,
  output logic [pscd_pkg::CMD_W-1:0]               o_dac_wr_data,
  output logic                                    o_top_phase_tick,
  output logic                                    o_pwm_cycle_start,
  output logic                                    o_phase_tick,
  output logic                                    o_servo_tick,
  output logic [pscd_pkg::N_CH-1:0]                o_commutate,
  output logic [pscd_pkg::N_CH-1:0]                o_servo_update,
  output logic [1:0][3:0]                         o_hw_clk_tick,
  output logic [1:0]                              o_dac_strobe,
  output logic [pscd_pkg::N_CH-1:0]                o_dac_sdata,
  output logic [pscd_pkg::N_CH*pscd_pkg::POS_W-1:0] o_enc_phase_pos,
  output logic [pscd_pkg::N_CH-1:0]                o_ab_dac_mode,
  output logic [pscd_pkg::N_CH-1:0]                o_c_pwm_mode,
  output logic [pscd_pkg::N_CH-1:0]                o_c_pfm_mode,
  output logic [pscd_pkg::N_CH-1:0]                o_fb_from_y,
  output logic [pscd_pkg::N_CH*pscd_pkg::ANG_W-1:0] o_angle_a,
  output logic [pscd_pkg::N_CH*pscd_pkg::ANG_W-1:0] o_angle_b
);
  import pscd_pkg::*;

  typedef struct packed {
    logic [NCO_W-1:0]                 top_acc;
    logic [1:0][3:0][NCO_W-1:0]       hw_acc;
    logic [DIV_W-1:0]                 ph_cnt;
    logic [DIV_W-1:0]                 sv_cnt;
    logic                             top_t;
    logic                             ph_t;
    logic                             sv_t;
    logic [N_CH-1:0]                  comm;
    logic [N_CH-1:0]                  supd;
    logic [1:0][3:0]                  hw_t;
    logic [1:0][STROBE_W-1:0]         strobe;
    logic [1:0][STROBE_W-1:0]         stb_sh;
    logic [1:0][4:0]                  bits;
    logic [N_CH-1:0][STROBE_W-1:0]    dsh;
    logic [1:0]                       stb_o;
    logic [N_CH-1:0]                  sd_o;
    logic [N_CH-1:0]                  a_s1, a_s2, b_s1, b_s2;
    logic [N_CH-1:0][1:0]             a_h, b_h;
    logic [N_CH-1:0]                  fa, fb;
    logic [N_CH-1:0][POS_W-1:0]       pos;
    logic [N_CH-1:0][ADR_W-1:0]       cmd_adr, fb_adr;
    logic [N_CH-1:0][FRAC_W-1:0]      frac;
    logic [N_CH-1:0][ANG_W-1:0]       ang, angb;
    logic [N_CH-1:0][CMD_W-1:0]       da, db;
    pscd_drain_t                      dst;
    logic [FIFO_W-1:0]                cur;
    logic                             wr_v;
    logic [ADR_W-1:0]                 wr_adr;
    logic [CMD_W-1:0]                 wr_dat;
    logic [N_CH-1:0]                  abm, pwm, pfm, fby;
  } pscd_st_t;

  pscd_st_t st_r, st_nxt;
  logic              f_valid, f_pop;
  logic [FIFO_W-1:0] f_data;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Fractional divider step on the master rate: returns tick and new accumulator.
  function automatic logic [NCO_W:0] nco(input logic [NCO_W-1:0] acc, input logic [NCO_W-1:0] lim);
    logic [NCO_W-1:0] l, s;
    l = (lim < MASTER_FREQ_DHZ) ? MASTER_FREQ_DHZ : lim;
    s = acc + MASTER_FREQ_DHZ;
    nco = (s >= l) ? {1'b1, s - l} : {1'b0, s};
  endfunction

  // Channel index of a per-channel register address; top bit says it matched.
  function automatic logic [3:0] chan_of(input logic [ADR_W-1:0] adr, input logic [15:0] base);
    logic [15:0] off;
    off = adr[15:0] - base;
    chan_of = {!adr[Y_REG_BIT] && (off[2:0] == 3'h0) && (off[15:6] == 10'h0), off[5:3]};
  endfunction

  pscd_fifo #(
    .W(FIFO_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_in_valid (i_cmd_valid),
    .o_in_ready (o_cmd_ready),
    .i_in_data  ({i_cmd_motor, i_cmd_a, i_cmd_b}),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data (f_data)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // All clocks, shifters, decoders and the write drain are computed here.
  always_comb begin
    logic [NCO_W:0]          r;
    logic [NCO_W-1:0]        lim;
    logic [HWSEL_W-1:0]      sel;
    logic [N_CH-1:0]         cstep, cup;
    logic                    na, nb, stp, up;
    logic [3:0]              dec, ch;
    logic [1:0]              md;
    logic signed [FRAC_W-1:0] f, c, inc;
    st_nxt = st_r;
    r = '0;
    lim = '0;
    sel = '0;
    cstep = '0;
    cup = '0;
    na = 1'b0;
    nb = 1'b0;
    stp = 1'b0;
    up = 1'b0;
    dec = '0;
    ch = '0;
    md = '0;
    f = '0;
    c = '0;
    inc = '0;
    f_pop = 1'b0;
    // Top phase clock from the master rate, two master cycles per setting step.
    lim = NCO_W'({1'b0, i_top_phase_divider, 1'b0} + 18'h2) * SYS_FREQ_DHZ;
    r = nco(st_r.top_acc, lim);
    st_nxt.top_acc = r[NCO_W-1:0];
    st_nxt.top_t = r[NCO_W];
    // Phase and servo dividers count down and reload from their settings.
    st_nxt.ph_t = 1'b0;
    st_nxt.sv_t = 1'b0;
    if (r[NCO_W]) begin
      if (st_r.ph_cnt == '0) begin
        st_nxt.ph_cnt = i_phase_clock_divider;
        st_nxt.ph_t = 1'b1;
      end else begin
        st_nxt.ph_cnt = st_r.ph_cnt - 1'b1;
      end
    end
    if (st_nxt.ph_t) begin
      if (st_r.sv_cnt == '0) begin
        st_nxt.sv_cnt = i_servo_clock_divider;
        st_nxt.sv_t = 1'b1;
      end else begin
        st_nxt.sv_cnt = st_r.sv_cnt - 1'b1;
      end
    end
    // Per-motor triggers follow the phase and servo ticks.
    st_nxt.comm = {N_CH{st_nxt.ph_t}} & i_commutation_enable;
    st_nxt.supd = {N_CH{st_nxt.sv_t}} & i_motor_activation;
    // Four hardware clocks per group, each the master over (field plus one).
    for (int g = 0; g < 2; g++) begin
      sel = (g == 0) ? i_hw_clock_select_low_group : i_hw_clock_select_high_group;
      for (int k = 0; k < 4; k++) begin
        lim = NCO_W'({1'b0, sel[k*8 +: 8]} + 9'h1) * SYS_FREQ_DHZ;
        r = nco(st_r.hw_acc[g][k], lim);
        st_nxt.hw_acc[g][k] = r[NCO_W-1:0];
        st_nxt.hw_t[g][k] = r[NCO_W];
      end
    end
    // Strobe words can be replaced by software per group.
    for (int g = 0; g < 2; g++) begin
      if (i_strobe_wr[g]) begin
        st_nxt.strobe[g] = i_strobe_value;
      end
    end
    // Serial strobe and data: load each phase cycle, shift one bit per DAC clock.
    for (int g = 0; g < 2; g++) begin
      if (st_r.ph_t) begin
        st_nxt.stb_sh[g] = st_r.strobe[g];
        st_nxt.bits[g] = 5'(STROBE_W);
        for (int k = g * 4; k < g * 4 + 4; k++) begin
          st_nxt.dsh[k] = {st_r.da[k], st_r.db[k]} ^ {STROBE_W{|i_dac_stream_inversion[k*4 +: 4]}};
        end
      end else if (st_r.hw_t[g][HW_DAC]) begin
        st_nxt.stb_o[g] = (st_r.bits[g] != '0) & st_r.stb_sh[g][STROBE_W-1];
        if (st_r.bits[g] != '0) begin
          st_nxt.stb_sh[g] = {st_r.stb_sh[g][STROBE_W-2:0], 1'b0};
          st_nxt.bits[g] = st_r.bits[g] - 1'b1;
        end
        for (int k = g * 4; k < g * 4 + 4; k++) begin
          st_nxt.sd_o[k] = (st_r.bits[g] != '0) & st_r.dsh[k][STROBE_W-1];
          st_nxt.dsh[k] = {st_r.dsh[k][STROBE_W-2:0], 1'b0};
        end
      end
    end
    // Encoder pins: two-stage synchroniser, then a three-sample delay filter.
    st_nxt.a_s1 = i_enc_a;
    st_nxt.b_s1 = i_enc_b;
    st_nxt.a_s2 = st_r.a_s1;
    st_nxt.b_s2 = st_r.b_s1;
    for (int k = 0; k < N_CH; k++) begin
      if (st_r.hw_t[k/4][HW_SCLK]) begin
        na = (st_r.a_h[k] == {2{st_r.a_s2[k]}}) ? st_r.a_s2[k] : st_r.fa[k];
        nb = (st_r.b_h[k] == {2{st_r.b_s2[k]}}) ? st_r.b_s2[k] : st_r.fb[k];
        st_nxt.a_h[k] = {st_r.a_h[k][0], st_r.a_s2[k]};
        st_nxt.b_h[k] = {st_r.b_h[k][0], st_r.b_s2[k]};
        st_nxt.fa[k] = na;
        st_nxt.fb[k] = nb;
        dec = i_encoder_decode_setting[k*4 +: 4];
        // One input changing is one quadrature edge; direction picked by decode value.
        cstep[k] = (st_r.fa[k] ^ na ^ st_r.fb[k] ^ nb) & ((dec == DEC_X4_FWD) | (dec == DEC_X4_REV));
        cup[k] = (st_r.fa[k] ^ nb) ^ (dec == DEC_X4_REV);
        if (cstep[k]) begin
          st_nxt.pos[k] = cup[k] ? st_r.pos[k] + 1'b1 : st_r.pos[k] - 1'b1;
        end
      end
    end
    // Output mode flags per channel.
    for (int k = 0; k < N_CH; k++) begin
      md = i_output_mode_setting[k*2 +: 2];
      st_nxt.abm[k] = (md == MODE_DAC_PWM) | (md == MODE_DAC_PFM);
      st_nxt.pwm[k] = (md == MODE_DAC_PWM);
      st_nxt.pfm[k] = (md == MODE_DAC_PFM);
    end
    // Address settings per motor.
    if (i_addr_wr) begin
      st_nxt.cmd_adr[i_addr_motor] = i_command_output_address;
      st_nxt.fb_adr[i_addr_motor] = i_commutation_feedback_address;
    end
    // Commutation angle: 256 parts per cycle, counts over cycles per part, kept fractional.
    for (int m = 0; m < N_CH; m++) begin
      st_nxt.fby[m] = st_r.fb_adr[m][Y_REG_BIT];
      ch = chan_of(st_r.fb_adr[m], ENC_POS_BASE);
      stp = st_r.fb_adr[m][Y_REG_BIT] ? i_ring_step[m] : (ch[3] & cstep[ch[2:0]]);
      up = st_r.fb_adr[m][Y_REG_BIT] ? i_ring_dir[m] : cup[ch[2:0]];
      inc = FRAC_W'({i_cycles_per_revolution[m*CYC_W +: CYC_W], 8'h00});
      c = FRAC_W'(i_counts_per_revolution[m*CNT_W +: CNT_W]);
      f = $signed(st_r.frac[m]);
      if (stp) begin
        f = up ? f + inc : f - inc;
      end
      if (c != '0) begin
        if (f >= c) begin
          f = f - c;
          st_nxt.ang[m] = st_r.ang[m] + 1'b1;
        end else if (f < 0) begin
          f = f + c;
          st_nxt.ang[m] = st_r.ang[m] - 1'b1;
        end
      end
      st_nxt.frac[m] = f;
      st_nxt.angb[m] = st_nxt.ang[m] + i_phase_a_to_b_angle[m*ANG_W +: ANG_W];
    end
    // Write drain: phase A to the output address, phase B to the next one.
    case (st_r.dst)
      DR_IDLE: begin
        if (f_valid) begin
          f_pop = 1'b1;
          st_nxt.cur = f_data;
          st_nxt.dst = DR_A;
          st_nxt.wr_v = 1'b1;
          st_nxt.wr_adr = st_r.cmd_adr[f_data[FIFO_W-1 -: 3]];
          st_nxt.wr_dat = f_data[2*CMD_W-1 -: CMD_W];
        end
      end
      DR_A: begin
        if (i_dac_wr_ready) begin
          ch = chan_of(st_r.wr_adr, DAC_A_BASE);
          if (ch[3]) begin
            st_nxt.da[ch[2:0]] = st_r.wr_dat;
          end
          st_nxt.dst = DR_B;
          st_nxt.wr_adr = st_r.wr_adr + 1'b1;
          st_nxt.wr_dat = st_r.cur[CMD_W-1:0];
        end
      end
      DR_B: begin
        if (i_dac_wr_ready) begin
          ch = chan_of(st_r.wr_adr - 1'b1, DAC_A_BASE);
          if (ch[3]) begin
            st_nxt.db[ch[2:0]] = st_r.wr_dat;
          end
          st_nxt.dst = DR_IDLE;
          st_nxt.wr_v = 1'b0;
        end
      end
      default: begin
        st_nxt.dst = DR_IDLE;
        st_nxt.wr_v = 1'b0;
      end
    endcase
    // Synchronous reset with default strobe words and per-channel addresses.
    if (!i_nrst) begin
      st_nxt = '0;
      f_pop = 1'b0;
      st_nxt.dst = DR_IDLE;
      st_nxt.strobe = {2{STROBE_DEFAULT}};
      for (int k = 0; k < N_CH; k++) begin
        st_nxt.cmd_adr[k] = {4'h0, DAC_A_BASE + CHAN_STRIDE * 16'(k)};
        st_nxt.fb_adr[k] = {4'h0, ENC_POS_BASE + CHAN_STRIDE * 16'(k)};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output except o_cmd_ready is a field of the state register; o_cmd_ready comes from the FIFO.
  assign o_top_phase_tick = st_r.top_t;
  assign o_pwm_cycle_start = st_r.top_t;
  assign o_phase_tick = st_r.ph_t;
  assign o_servo_tick = st_r.sv_t;
  assign o_commutate = st_r.comm;
  assign o_servo_update = st_r.supd;
  assign o_hw_clk_tick = st_r.hw_t;
  assign o_dac_strobe = st_r.stb_o;
  assign o_dac_sdata = st_r.sd_o;
  assign o_enc_phase_pos = st_r.pos;
  assign o_ab_dac_mode = st_r.abm;
  assign o_c_pwm_mode = st_r.pwm;
  assign o_c_pfm_mode = st_r.pfm;
  assign o_fb_from_y = st_r.fby;
  assign o_angle_a = st_r.ang;
  assign o_angle_b = st_r.angb;
  assign o_dac_wr_valid = st_r.wr_v;
  assign o_dac_wr_addr = st_r.wr_adr;
  assign o_dac_wr_data = st_r.wr_dat;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  top_tick_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_top_phase_tick && i_top_phase_divider >= 16'h0005 && $stable(i_top_phase_divider)) |=> !o_top_phase_tick)
    else $error("top phase ticks too close");
  pwm_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pwm_cycle_start == o_top_phase_tick)
    else $error("PWM start not on top phase tick");
  phase_sub_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_phase_tick |-> o_top_phase_tick)
    else $error("phase tick without top phase tick");
  servo_sub_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_servo_tick |-> o_phase_tick)
    else $error("servo tick without phase tick");
  commute_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_commutate != '0) |-> (o_phase_tick && ((o_commutate & ~$past(i_commutation_enable)) == '0)))
    else $error("commutation trigger on disabled motor");
  servo_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_servo_update != '0) |-> (o_servo_tick && ((o_servo_update & ~$past(i_motor_activation)) == '0)))
    else $error("servo update on inactive motor");
  strobe_load_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_phase_tick |=> (st_r.bits[0] == 5'(STROBE_W) && st_r.stb_sh[1] == $past(st_r.strobe[1])))
    else $error("strobe word not loaded on phase tick");
  dac_mode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($past(i_nrst) && $past(i_output_mode_setting[1:0]) == MODE_DAC_PFM)
    |-> (o_ab_dac_mode[0] && o_c_pfm_mode[0] && !o_c_pwm_mode[0]))
    else $error("output mode 3 not decoded");
endmodule
`default_nettype wire
